// ==== design/rsc_regs.svh ====
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RSC_ADDR_W            12
`define RSC_CAUSE_OFFSET      12'h000
`define RSC_BACKUP_OFFSET     12'h004

// ----------------------------------------
// Cause and control register fields
// ----------------------------------------
`define RSC_BIT_POR           0
`define RSC_BIT_BOR           1
`define RSC_BIT_IDLE          2
`define RSC_BIT_SLEEP         3
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG          4
`define RSC_BIT_SOFT_WATCHDOG_ENABLE        5
`define RSC_BIT_SWR           6
`define RSC_BIT_PIN_RESET_FLAG          7
`define RSC_BIT_PROGMEM_SLEEP_POWER         8
`define RSC_BIT_CM            9
`define RSC_BIT_DEEP_SLEEP_HISTORY_FLAG         10
`define RSC_BIT_RETENTION_ENABLE         12
`define RSC_BIT_ILLOP         14
`define RSC_BIT_TRAP          15
`define RSC_CAUSE_POR_VALUE   16'h0003
`define RSC_CAUSE_WMASK       16'hD7FF

// ----------------------------------------
// Backup power reset status field
// ----------------------------------------
`define RSC_BIT_BKUP_RST      0
`define RSC_BACKUP_POR_VALUE  1'h0

// ----------------------------------------
// Reset source vector positions
// ----------------------------------------
`define RSC_NUM_SRC           8
`define RSC_SRC_BROWNOUT      0
`define RSC_SRC_PIN           1
`define RSC_SRC_INSTR         2
`define RSC_SRC_WDT           3
`define RSC_SRC_CFGMIS        4
`define RSC_SRC_TRAP          5
`define RSC_SRC_ILLOP         6
`define RSC_SRC_UWR           7

`endif

// ==== design/rsc_pkg.sv ====
package rsc_pkg;

  // ----------------------------------------
  // Shared types
  // ----------------------------------------
  typedef logic [15:0] rsc_cause_t;
  typedef logic [7:0]  rsc_src_t;
  typedef logic [11:0] rsc_addr_t;

endpackage : rsc_pkg

// ==== design/rsc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module rsc_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
    end
    else
    begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;

endmodule : rsc_sync2

`default_nettype wire

// ==== design/rsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rsc_regs.svh"

// What this block does
// - Master system reset is asserted while any reset source is active.
// - Sources: power-on, brown-out, pin, instruction, watchdog, mismatch, trap, illegal, uninit.
// - Every reset sets the cause flag matching its source.
// - Power-on clears the cause register except brown-out and power-on flags, which set.
// - Software may set or clear any flag; setting never causes a reset.
// - Register keeps its contents across every reset except power-on.
// - Resets other than power-on during backup power also set a flag in the second status register.
// - Bit 15 records a trap conflict reset.
// - Bit 14 records illegal opcode, addressing mode or uninitialised pointer reset.
// - Bit 12 selects retention regulator in Sleep, ignored when fuse unprogrammed.
// - Bit 10 records that the device has been in Deep Sleep.
// - Bit 9 records a configuration mismatch reset.
// - Bit 8 keeps program memory bias powered during Sleep.
// - Bit 7 records a reset from the external clear pin.
// - Bit 6 records a reset instruction.
// - Bit 5 enables the watchdog; unprogrammed fuse keeps it always enabled.
// - Bit 4 records a watchdog time-out.
// - Bit 3 records that the device has been in Sleep.
// - Bit 2 records that the device has been in Idle.
// - Bit 1 records brown-out, and is also set after power-on.
// - Bit 0 records a power-on reset.
// - Watchdog flag cleared by watchdog clear, power save instruction and power-on.
module rsc_top (
  // Clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources
  input  wire logic        brownout_detect,
  input  wire logic        external_clear_pin_n,
  input  wire logic        reset_instruction,
  input  wire logic        watchdog_timeout,
  input  wire logic        config_mismatch,
  input  wire logic        trap_conflict,
  input  wire logic        illegal_op,
  input  wire logic        uninit_wreg_reset,
  // Power state events
  input  wire logic        power_save_sleep,
  input  wire logic        power_save_idle,
  input  wire logic        deep_sleep_enable,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        backup_power_active,
  // Configuration fuses
  input  wire logic        low_power_regulator_fuse,
  input  wire logic        watchdog_fuse,
  // Reset and power control outputs
  output logic             master_system_reset,
  output logic             retention_regulator_on,
  output logic             progmem_bias_in_sleep,
  output logic             watchdog_enable
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic [1:0] rsc_decode(input rsc_pkg::rsc_addr_t addr);
    logic [1:0] hit;
    hit = 2'h0;
    if (addr == `RSC_CAUSE_OFFSET)
      hit[0] = 1'b1;
    if (addr == `RSC_BACKUP_OFFSET)
      hit[1] = 1'b1;
    return hit;
  endfunction : rsc_decode

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  rsc_pkg::rsc_src_t   src_raw;
  rsc_pkg::rsc_src_t   src_sync;
  logic                any_src;
  logic                bkup_sync;
  logic                master_r;
  rsc_pkg::rsc_cause_t cause_r;
  rsc_pkg::rsc_cause_t cause_nxt;
  rsc_pkg::rsc_cause_t wr_mask;
  logic                bkup_r;
  logic                bkup_nxt;
  logic [1:0]          wr_hit;
  logic [1:0]          rd_hit;
  logic                wr_en;
  logic                rd_setup;
  logic [31:0]         prdata_r;
  logic                pslverr_r;

  // ----------------------------------------
  // Reset source gathering and sync
  // ----------------------------------------
  always_comb
  begin
    src_raw                     = '0;
    src_raw[`RSC_SRC_BROWNOUT]  = brownout_detect;
    src_raw[`RSC_SRC_PIN]       = ~external_clear_pin_n;
    src_raw[`RSC_SRC_INSTR]     = reset_instruction;
    src_raw[`RSC_SRC_WDT]       = watchdog_timeout;
    src_raw[`RSC_SRC_CFGMIS]    = config_mismatch;
    src_raw[`RSC_SRC_TRAP]      = trap_conflict;
    src_raw[`RSC_SRC_ILLOP]     = illegal_op;
    src_raw[`RSC_SRC_UWR]       = uninit_wreg_reset;
  end

  rsc_sync2 #(
    .WIDTH    (`RSC_NUM_SRC + 1)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({backup_power_active, src_raw}),
    .sync_out ({bkup_sync, src_sync})
  );

  assign any_src = |src_sync;

  // ----------------------------------------
  // Master system reset
  // ----------------------------------------
  // Power-on holds it through presetn; others follow the OR of sources
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      master_r <= 1'b1;
    else
      master_r <= any_src;
  end

  assign master_system_reset = master_r;

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  assign wr_hit   = rsc_decode(paddr);
  assign rd_hit   = wr_hit;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign pready   = 1'b1;

  always_comb
  begin
    wr_mask = '0;
    if (pstrb[0])
      wr_mask[7:0] = 8'hFF;
    if (pstrb[1])
      wr_mask[15:8] = 8'hFF;
    wr_mask = wr_mask & `RSC_CAUSE_WMASK;
  end

  // ----------------------------------------
  // Cause and control register next value
  // ----------------------------------------
  always_comb
  begin
    cause_nxt = cause_r;
    if (wr_en && wr_hit[0])
      cause_nxt = (cause_r & ~wr_mask) | (pwdata[15:0] & wr_mask);
    if (watchdog_clear_instruction || power_save_sleep || power_save_idle)
      cause_nxt[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    // Hardware sets win over software and instruction clears
    if (src_sync[`RSC_SRC_TRAP])
      cause_nxt[`RSC_BIT_TRAP] = 1'b1;
    if (src_sync[`RSC_SRC_ILLOP] || src_sync[`RSC_SRC_UWR])
      cause_nxt[`RSC_BIT_ILLOP] = 1'b1;
    if (src_sync[`RSC_SRC_CFGMIS])
      cause_nxt[`RSC_BIT_CM] = 1'b1;
    if (src_sync[`RSC_SRC_PIN])
      cause_nxt[`RSC_BIT_PIN_RESET_FLAG] = 1'b1;
    if (src_sync[`RSC_SRC_INSTR])
      cause_nxt[`RSC_BIT_SWR] = 1'b1;
    if (src_sync[`RSC_SRC_WDT])
      cause_nxt[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    if (src_sync[`RSC_SRC_BROWNOUT])
      cause_nxt[`RSC_BIT_BOR] = 1'b1;
    if (power_save_sleep)
      cause_nxt[`RSC_BIT_SLEEP] = 1'b1;
    if (power_save_sleep && deep_sleep_enable)
      cause_nxt[`RSC_BIT_DEEP_SLEEP_HISTORY_FLAG] = 1'b1;
    if (power_save_idle)
      cause_nxt[`RSC_BIT_IDLE] = 1'b1;
    cause_nxt = cause_nxt & `RSC_CAUSE_WMASK;
  end

  // Only power-on clears it; the other resets leave it as it is
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_r <= `RSC_CAUSE_POR_VALUE;
    else
      cause_r <= cause_nxt;
  end

  // ----------------------------------------
  // Backup power reset status
  // ----------------------------------------
  // Clear-only by software writing zero; hardware set wins
  always_comb
  begin
    bkup_nxt = bkup_r;
    if (wr_en && wr_hit[1] && pstrb[0] && !pwdata[`RSC_BIT_BKUP_RST])
      bkup_nxt = 1'b0;
    if (any_src && bkup_sync)
      bkup_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bkup_r <= `RSC_BACKUP_POR_VALUE;
    else
      bkup_r <= bkup_nxt;
  end

  // ----------------------------------------
  // Read data and error response
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (rd_setup)
    begin
      prdata_r <= '0;
      if (rd_hit[0])
        prdata_r[15:0] <= cause_r;
      else if (rd_hit[1])
        prdata_r[`RSC_BIT_BKUP_RST] <= bkup_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_r <= 1'b0;
    else if (rd_setup)
      pslverr_r <= ~|rd_hit;
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // ----------------------------------------
  // Power and watchdog control
  // ----------------------------------------
  // Unprogrammed fuse reads as one
  assign retention_regulator_on = cause_r[`RSC_BIT_RETENTION_ENABLE] & ~low_power_regulator_fuse;
  assign progmem_bias_in_sleep  = cause_r[`RSC_BIT_PROGMEM_SLEEP_POWER];
  assign watchdog_enable        = cause_r[`RSC_BIT_SOFT_WATCHDOG_ENABLE] | watchdog_fuse;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_master_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    any_src |=> master_system_reset)
    else $error("master reset not asserted after active source");

  a_master_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    !any_src |=> !master_system_reset)
    else $error("master reset held with no active source");

  a_soft_no_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && wr_hit[0] && !any_src) |=> !master_system_reset)
    else $error("software write caused a reset");

  a_trap_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(src_sync[`RSC_SRC_TRAP]) |=> cause_r[`RSC_BIT_TRAP])
    else $error("trap conflict flag not set");

  a_illop_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (src_sync[`RSC_SRC_ILLOP] || src_sync[`RSC_SRC_UWR]) |=> cause_r[`RSC_BIT_ILLOP])
    else $error("illegal operation flag not set");

  a_pin_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(src_sync[`RSC_SRC_PIN]) |=> cause_r[`RSC_BIT_PIN_RESET_FLAG])
    else $error("pin reset flag not set");

  a_watchdog_timeout_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (watchdog_clear_instruction && !src_sync[`RSC_SRC_WDT])
      |=> !cause_r[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not cleared by clear instruction");

  a_watchdog_timeout_flag_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    (src_sync[`RSC_SRC_WDT] && watchdog_clear_instruction) |=> cause_r[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag lost to simultaneous clear");

  a_unimpl_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cause_r[13] == 1'b0) && (cause_r[11] == 1'b0))
    else $error("unimplemented bits not zero");

  a_deep_sleep: assert property (
    @(posedge pclk) disable iff (!presetn)
    (power_save_sleep && deep_sleep_enable)
      |=> cause_r[`RSC_BIT_DEEP_SLEEP_HISTORY_FLAG] && cause_r[`RSC_BIT_SLEEP])
    else $error("deep sleep history not recorded");

  a_wdt_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    watchdog_fuse |-> watchdog_enable)
    else $error("watchdog disabled with fuse unprogrammed");

  a_retention_fuse: assert property (
    @(posedge pclk) disable iff (!presetn)
    low_power_regulator_fuse |-> !retention_regulator_on)
    else $error("retention on with fuse unprogrammed");

  a_backup_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (any_src && bkup_sync) |=> bkup_r ##1 bkup_r || !any_src)
    else $error("backup reset flag not set");

  a_bor_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    src_sync[`RSC_SRC_BROWNOUT] |=> cause_r[`RSC_BIT_BOR] && master_system_reset)
    else $error("brown-out flag or reset missing");

endmodule : rsc_top

`default_nettype wire

// ==== dv/rsc_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rsc_regs.svh"

module rsc_src_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the bench
  input  wire logic       go,
  input  wire logic [7:0] mask,
  input  wire logic [7:0] hold,
  // Reset source levels
  output logic            brownout_detect,
  output logic            external_clear_pin_n,
  output logic            reset_instruction,
  output logic            watchdog_timeout,
  output logic            config_mismatch,
  output logic            trap_conflict,
  output logic            illegal_op,
  output logic            uninit_wreg_reset
);
  logic [7:0] cnt_r [8];
  logic [7:0] act;

  // ----------------------------------------
  // Per-source hold counters
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < 8; k++)
        cnt_r[k] <= 8'h00;
    end
    else
    begin
      for (int k = 0; k < 8; k++)
      begin
        if (go && mask[k])
          cnt_r[k] <= hold;
        else if (cnt_r[k] != 8'h00)
          cnt_r[k] <= cnt_r[k] - 8'h01;
      end
    end
  end

  always_comb
  begin
    for (int k = 0; k < 8; k++)
      act[k] = (cnt_r[k] != 8'h00);
  end

  assign brownout_detect      = act[`RSC_SRC_BROWNOUT];
  assign external_clear_pin_n = ~act[`RSC_SRC_PIN];
  assign reset_instruction    = act[`RSC_SRC_INSTR];
  assign watchdog_timeout     = act[`RSC_SRC_WDT];
  assign config_mismatch      = act[`RSC_SRC_CFGMIS];
  assign trap_conflict        = act[`RSC_SRC_TRAP];
  assign illegal_op           = act[`RSC_SRC_ILLOP];
  assign uninit_wreg_reset    = act[`RSC_SRC_UWR];
endmodule : rsc_src_model

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "rsc_regs.svh"

module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, err, go = 1'b0;
  logic [7:0]  mask = 8'h00, hold = 8'h00, m;
  logic        brownout_detect, external_clear_pin_n, reset_instruction, watchdog_timeout;
  logic        config_mismatch, trap_conflict, illegal_op, uninit_wreg_reset;
  logic        power_save_sleep = 1'b0, power_save_idle = 1'b0, deep_sleep_enable = 1'b0;
  logic        watchdog_clear_instruction = 1'b0, backup_power_active = 1'b0;
  logic        low_power_regulator_fuse = 1'b0, watchdog_fuse = 1'b0;
  logic        master_system_reset, retention_regulator_on, progmem_bias_in_sleep;
  logic        watchdog_enable;
  int          fail_count = 0, comparisons = 0, seed = 32'h4139EFCC, k, j;
  logic [15:0] exp_cause;
  logic [15:0] src_bit [8] = '{16'h0002, 16'h0080, 16'h0040, 16'h0010,
                               16'h0200, 16'h8000, 16'h4000, 16'h4000};

  rsc_top u_dut (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .pstrb                      (pstrb),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .brownout_detect            (brownout_detect),
    .external_clear_pin_n       (external_clear_pin_n),
    .reset_instruction          (reset_instruction),
    .watchdog_timeout           (watchdog_timeout),
    .config_mismatch            (config_mismatch),
    .trap_conflict              (trap_conflict),
    .illegal_op                 (illegal_op),
    .uninit_wreg_reset          (uninit_wreg_reset),
    .power_save_sleep           (power_save_sleep),
    .power_save_idle            (power_save_idle),
    .deep_sleep_enable          (deep_sleep_enable),
    .watchdog_clear_instruction (watchdog_clear_instruction),
    .backup_power_active        (backup_power_active),
    .low_power_regulator_fuse   (low_power_regulator_fuse),
    .watchdog_fuse              (watchdog_fuse),
    .master_system_reset        (master_system_reset),
    .retention_regulator_on     (retention_regulator_on),
    .progmem_bias_in_sleep      (progmem_bias_in_sleep),
    .watchdog_enable            (watchdog_enable)
  );

  rsc_src_model u_src (
    .pclk                 (pclk),
    .presetn              (presetn),
    .go                   (go),
    .mask                 (mask),
    .hold                 (hold),
    .brownout_detect      (brownout_detect),
    .external_clear_pin_n (external_clear_pin_n),
    .reset_instruction    (reset_instruction),
    .watchdog_timeout     (watchdog_timeout),
    .config_mismatch      (config_mismatch),
    .trap_conflict        (trap_conflict),
    .illegal_op           (illegal_op),
    .uninit_wreg_reset    (uninit_wreg_reset)
  );

  always #12.5 pclk = ~pclk;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wait_msr(input logic val);
    int n;
    n = 0;
    while (master_system_reset !== val && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk("master_system_reset", {31'h0, master_system_reset}, {31'h0, val});
    if (master_system_reset !== val)
      tally_and_finish();
  endtask : wait_msr

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    logic ok;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    ok = (pready === 1'b1);
    chk("pready", {31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (!ok)
      tally_and_finish();
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [15:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, {16'h0, e});
  endtask : rdchk

  task automatic fire(input logic [7:0] mk, input logic [7:0] hd);
    go   <= 1'b1;
    mask <= mk;
    hold <= hd;
    @(posedge pclk);
    go <= 1'b0;
    for (int b = 0; b < 8; b++)
      if (mk[b])
        exp_cause |= src_bit[b];
    @(posedge pclk);
  endtask : fire

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_cause = 16'h0003;
    rdchk(`RSC_CAUSE_OFFSET, exp_cause, "cause");
    rdchk(`RSC_BACKUP_OFFSET, 16'h0, "backup");
    chk("master_system_reset", {31'h0, master_system_reset}, 32'h0);
    apb(1'b1, 12'h010, 32'hFFFF);
    chk("pslverr", {31'h0, err}, 32'h1);
    $display("power-on test done");
    for (k = 0; k < 4; k++)
    begin
      d = (k == 0) ? 32'hFFFFFFFF : $random(seed);
      apb(1'b1, `RSC_CAUSE_OFFSET, d);
      exp_cause = d[15:0] & 16'hD7FF;
      repeat (4) @(posedge pclk);
      chk("master_system_reset", {31'h0, master_system_reset}, 32'h0);
      rdchk(`RSC_CAUSE_OFFSET, exp_cause, "cause");
      for (j = 0; j < 4; j++)
      begin
        {low_power_regulator_fuse, watchdog_fuse} <= j[1:0];
        repeat (2) @(posedge pclk);
        chk("retention", {31'h0, retention_regulator_on}, {31'h0, exp_cause[12] & ~j[1]});
        chk("progmem_bias", {31'h0, progmem_bias_in_sleep}, {31'h0, exp_cause[8]});
        chk("watchdog_enable", {31'h0, watchdog_enable}, {31'h0, exp_cause[5] | j[0]});
      end
    end
    $display("software write test done");
    for (k = 0; k < 8; k++)
    begin
      apb(1'b1, `RSC_CAUSE_OFFSET, 32'h0);
      exp_cause = 16'h0;
      fire(8'h01 << k, 8'h04 + k[7:0]);
      @(posedge pclk);
      watchdog_clear_instruction <= (k == 3);
      @(posedge pclk);
      watchdog_clear_instruction <= 1'b0;
      wait_msr(1'b1);
      wait_msr(1'b0);
      rdchk(`RSC_CAUSE_OFFSET, exp_cause, "cause");
    end
    $display("single source test done");
    repeat (4)
    begin
      apb(1'b1, `RSC_CAUSE_OFFSET, 32'h0);
      exp_cause = 16'h0;
      m = 8'($random(seed));
      fire(m | 8'h01, 8'h10);
      fire(~m & 8'hFE, 8'h03);
      repeat (6) @(posedge pclk);
      chk("master_system_reset", {31'h0, master_system_reset}, 32'h1);
      wait_msr(1'b0);
      rdchk(`RSC_CAUSE_OFFSET, exp_cause, "cause");
    end
    $display("overlapping source test done");
    deep_sleep_enable <= 1'b1;
    for (k = 0; k < 3; k++)
    begin
      apb(1'b1, `RSC_CAUSE_OFFSET, 32'h10);
      {watchdog_clear_instruction, power_save_idle, power_save_sleep} <= 3'h1 << k;
      @(posedge pclk);
      {watchdog_clear_instruction, power_save_idle, power_save_sleep} <= 3'h0;
      @(posedge pclk);
      exp_cause = (k == 0) ? 16'h0408 : (k == 1) ? 16'h0004 : 16'h0000;
      rdchk(`RSC_CAUSE_OFFSET, exp_cause, "cause");
    end
    $display("power event test done");
    backup_power_active <= 1'b1;
    fire(8'h01, 8'h04);
    wait_msr(1'b1);
    wait_msr(1'b0);
    rdchk(`RSC_BACKUP_OFFSET, 16'h1, "backup");
    backup_power_active <= 1'b0;
    apb(1'b1, `RSC_BACKUP_OFFSET, 32'h0);
    rdchk(`RSC_BACKUP_OFFSET, 16'h0, "backup");
    $display("backup power test done");
    apb(1'b1, `RSC_CAUSE_OFFSET, 32'hD7FC);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("master_system_reset", {31'h0, master_system_reset}, 32'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    exp_cause = 16'h0003;
    rdchk(`RSC_CAUSE_OFFSET, exp_cause, "cause");
    $display("second power-on test done");
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
